//--- hw/lmc_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

//
// Contract
// - Transceiver starts off after reset; off selectable in every chip mode.
// - In off mode bus wake activity is ignored; no wake indication.
// - Normal mode accepted only in chip normal or stop mode.
// - Transmit input low at enable end: wait for high, send next dominant.
// - Receive-only disables driver, receive output follows bus; normal/stop only.
// - Wake mode selectable in stop/sleep/restart/normal; forced in fail-safe.
// - Wake recognised only when bus dominant longer than wake filter time.
// - On wake, receive output held low until software changes mode or chip enters stop, sleep or fail-safe.
// - After wake, mode field still reads wake code, wake not rearmed.
// - Software rearm only after switching through normal, receive-only or off.
// - Rearm automatically on chip entry to stop, sleep or fail-safe.
// - Wake in stop/normal pulses interrupt and sets bus wake status flag.
// - Wake in stop keeps chip in stop; host commands normal itself.
// - Wake in stop re-enables disabled watchdog when wake-enable bit high.
// - Wake in sleep/fail-safe/restart requests restart mode, no interrupt.
// - Transmit dominant beyond timeout: driver off, fault set, mode kept.
// - Driver re-enabled once transmit input no longer dominant.
// - Bus dominant beyond bus timeout sets fault in every mode.
// - Bus supply undervoltage disables driver and receiver; mode kept.
// - Normal slope by default; low-slope bit only changes slew rate.
// - Low-slope bit applied at chip select rise, in chip normal only.
// - Flash bit in chip normal bypasses slope control at chip select rise.
module lmc_mode_ctrl #(
   parameter int TX_TIMEOUT_CYC   = lmc_pkg::TX_TIMEOUT_CYC,
   parameter int BUS_TIMEOUT_CYC  = lmc_pkg::BUS_TIMEOUT_CYC,
   parameter int WAKE_FILTER_CYC  = lmc_pkg::WAKE_FILTER_CYC,
   parameter int ENABLE_DELAY_CYC = lmc_pkg::ENABLE_DELAY_CYC
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              srst,
   // SPI staged configuration
   input  wire lmc_pkg::lmc_cfg_t spi_cfg,
   input  wire logic              spi_cfg_valid,
   output logic                   spi_cfg_ready,
   input  wire logic              spi_csn,
   // Chip state
   input  wire lmc_pkg::lmc_chip_t chip_mode,
   input  wire logic              wdog_disabled,
   input  wire logic              wdog_on_bus_wake,
   input  wire logic              fault_clear,
   // Pins
   input  wire logic              lin_tx_in,
   input  wire logic              bus_rx,
   input  wire logic              bus_supply_ok,
   // Driver and receiver control
   output logic                   bus_drive_dom,
   output logic                   lin_rx_out,
   output logic                   low_slope,
   output logic                   slope_bypass,
   // Status
   output lmc_pkg::lmc_mode_t     lin_mode_field,
   output logic                   lin_fault_flag,
   output logic                   wake_status_reg,
   output logic                   wake_irq,
   output logic                   wake_restart_req,
   output logic                   wdog_enable_req
);
   // Refuse timing values that the counters cannot hold
   if (TX_TIMEOUT_CYC < 2 || BUS_TIMEOUT_CYC < 2 || WAKE_FILTER_CYC < 2 || ENABLE_DELAY_CYC < 1
       || TX_TIMEOUT_CYC >= (1 << lmc_pkg::CNT_W) || BUS_TIMEOUT_CYC >= (1 << lmc_pkg::CNT_W)
       || WAKE_FILTER_CYC >= (1 << lmc_pkg::CNT_W) || ENABLE_DELAY_CYC >= (1 << lmc_pkg::CNT_W)) begin : g_bad_timing
      $error("lmc_mode_ctrl: timing parameters out of range");
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] tx_s, rx_s, csn_s, uv_s;
   always_ff @(posedge clk_sys) begin
      tx_s  <= {tx_s[0], lin_tx_in};
      rx_s  <= {rx_s[0], bus_rx};
      csn_s <= {csn_s[0], spi_csn};
      uv_s  <= {uv_s[0], bus_supply_ok};
   end
   wire tx_dom  = ~tx_s[1];
   wire bus_dom = ~rx_s[1];
   wire csn_hi  = csn_s[1];
   wire sup_ok  = uv_s[1];
   logic csn_d;
   always_ff @(posedge clk_sys) csn_d <= srst ? 1'b1 : csn_hi;
   wire csn_rise = csn_hi & ~csn_d;

   // ----------------------------------------
   // Two-entry buffer for SPI configuration words
   // ----------------------------------------
   lmc_pkg::lmc_cfg_t buf_q [2];
   logic [1:0] buf_cnt;
   logic       buf_rd, buf_wr, buf_wi;
   assign buf_wr = spi_cfg_valid & spi_cfg_ready;
   // Write slot; a full buffer never takes a word
   assign buf_wi = buf_cnt[0] & ~buf_rd;
   assign buf_rd = csn_rise & (buf_cnt != 2'h0);
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         buf_cnt       <= 2'h0;
         spi_cfg_ready <= 1'b0;
      end else begin
         if (buf_wr)
            buf_q[buf_wi] <= spi_cfg;
         if (buf_rd)
            buf_q[0] <= buf_q[1];
         if (buf_rd && buf_wr && buf_cnt == 2'h1)
            buf_q[0] <= spi_cfg;
         buf_cnt       <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
         spi_cfg_ready <= (buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd}) < 2'h2;
      end
   end
   wire lmc_pkg::lmc_cfg_t head = buf_q[0];

   // ----------------------------------------
   // Mode acceptance per chip mode
   // ----------------------------------------
   wire chip_nrm  = chip_mode == lmc_pkg::LMC_CHIP_NORMAL;
   wire chip_stop = chip_mode == lmc_pkg::LMC_CHIP_STOP;
   wire chip_slp  = chip_mode == lmc_pkg::LMC_CHIP_SLEEP;
   wire chip_rst  = chip_mode == lmc_pkg::LMC_CHIP_RESTART;
   wire chip_fs   = chip_mode == lmc_pkg::LMC_CHIP_FAIL;
   wire ok_norm   = chip_nrm | chip_stop;
   wire ok_wake   = chip_nrm | chip_stop | chip_slp | chip_rst;
   wire mode_ok   = (head.mode == lmc_pkg::LMC_OFF)
                  | ((head.mode == lmc_pkg::LMC_NORMAL) & ok_norm)
                  | ((head.mode == lmc_pkg::LMC_RXONLY) & ok_norm)
                  | ((head.mode == lmc_pkg::LMC_WAKE) & ok_wake);
   wire mode_wr   = buf_rd & mode_ok;
   lmc_pkg::lmc_chip_t chip_d;
   always_ff @(posedge clk_sys) chip_d <= srst ? lmc_pkg::LMC_CHIP_NORMAL : chip_mode;
   wire chip_chg  = chip_d != chip_mode;
   // forced on fail-safe entry; off stays selectable afterwards
   wire force_wk  = chip_chg & chip_fs;

   // ----------------------------------------
   // Mode field and slope bits
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         lin_mode_field <= lmc_pkg::LMC_OFF;
         low_slope      <= 1'b0;
         slope_bypass   <= 1'b0;
      end else begin
         if (force_wk)
            lin_mode_field <= lmc_pkg::LMC_WAKE;
         else if (mode_wr)
            lin_mode_field <= head.mode;
         if (buf_rd && chip_nrm) begin
            low_slope    <= head.low_slope_select;
            slope_bypass <= head.flash_select;
         end
      end
   end

   // ----------------------------------------
   // Wake filter and wake FSM
   // ----------------------------------------
   lmc_pkg::lmc_wk_t wk, next_wk;
   logic [lmc_pkg::CNT_W-1:0] wk_cnt;
   wire in_wake   = lin_mode_field == lmc_pkg::LMC_WAKE;
   wire wk_hit    = bus_dom & sup_ok & (wk_cnt == lmc_pkg::CNT_W'(WAKE_FILTER_CYC));
   wire rearm     = (mode_wr & head.mode != lmc_pkg::LMC_WAKE)
                  | (chip_chg & (chip_stop | chip_slp | chip_fs));
   always_comb begin
      next_wk = wk;
      case (wk)
         lmc_pkg::LMC_WK_IDLE:  if (in_wake) next_wk = lmc_pkg::LMC_WK_ARMED;
         lmc_pkg::LMC_WK_ARMED: if (!in_wake) next_wk = lmc_pkg::LMC_WK_IDLE;
                                else if (wk_hit) next_wk = lmc_pkg::LMC_WK_WOKEN;
         lmc_pkg::LMC_WK_WOKEN: if (rearm) next_wk = lmc_pkg::LMC_WK_IDLE;
         default:               next_wk = lmc_pkg::LMC_WK_IDLE;
      endcase
   end
   wire wake_ev = (wk == lmc_pkg::LMC_WK_ARMED) & in_wake & wk_hit;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wk     <= lmc_pkg::LMC_WK_IDLE;
         wk_cnt <= '0;
      end else begin
         wk     <= next_wk;
         wk_cnt <= (bus_dom && wk == lmc_pkg::LMC_WK_ARMED && wk_cnt != lmc_pkg::CNT_W'(WAKE_FILTER_CYC))
                   ? wk_cnt + 1'b1 : '0;
      end
   end

   // ----------------------------------------
   // Wake reporting
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wake_status_reg  <= 1'b0;
         wake_irq         <= 1'b0;
         wake_restart_req <= 1'b0;
         wdog_enable_req  <= 1'b0;
      end else begin
         // status and interrupt; set wins over clear
         wake_status_reg  <= wake_ev | (wake_status_reg & ~fault_clear);
         wake_irq         <= wake_ev & (chip_nrm | chip_stop);
         // restart only from sleep, restart, fail-safe
         wake_restart_req <= wake_ev & (chip_slp | chip_rst | chip_fs);
         wdog_enable_req  <= wake_ev & chip_stop & wdog_disabled & wdog_on_bus_wake;
      end
   end

   // ----------------------------------------
   // Enable delay and transmit arming
   // ----------------------------------------
   logic [lmc_pkg::CNT_W-1:0] en_cnt;
   logic tx_armed;
   wire  tx_mode = lin_mode_field == lmc_pkg::LMC_NORMAL;
   wire  en_done = en_cnt == lmc_pkg::CNT_W'(ENABLE_DELAY_CYC);
   always_ff @(posedge clk_sys) begin
      if (srst || !tx_mode) begin
         en_cnt   <= '0;
         tx_armed <= 1'b0;
      end else begin
         if (!en_done)
            en_cnt <= en_cnt + 1'b1;
         // arm only after a recessive input
         if (en_done && !tx_dom)
            tx_armed <= 1'b1;
      end
   end

   // ----------------------------------------
   // Timeouts
   // ----------------------------------------
   logic [lmc_pkg::CNT_W-1:0] tx_cnt, bus_cnt;
   logic tx_to;
   wire  tx_exp  = tx_cnt == lmc_pkg::CNT_W'(TX_TIMEOUT_CYC);
   wire  bus_exp = bus_cnt == lmc_pkg::CNT_W'(BUS_TIMEOUT_CYC);
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tx_cnt         <= '0;
         bus_cnt        <= '0;
         tx_to          <= 1'b0;
         lin_fault_flag <= 1'b0;
      end else begin
         tx_cnt  <= (tx_dom && tx_armed && !tx_exp) ? tx_cnt + 1'b1 : (tx_dom && tx_armed ? tx_cnt : '0);
         bus_cnt <= (bus_dom && !bus_exp) ? bus_cnt + 1'b1 : (bus_dom ? bus_cnt : '0);
         tx_to   <= tx_dom & (tx_to | tx_exp);
         // fault set, set wins over clear
         lin_fault_flag <= (tx_exp | bus_exp) | (lin_fault_flag & ~fault_clear);
      end
   end

   // ----------------------------------------
   // Driver and receiver outputs
   // ----------------------------------------
   // driver gating
   wire next_drive = tx_mode & tx_armed & tx_dom & ~tx_to & ~tx_exp & sup_ok;
   wire rx_follow  = (tx_mode | lin_mode_field == lmc_pkg::LMC_RXONLY) & sup_ok;
   wire next_rx    = (wk == lmc_pkg::LMC_WK_WOKEN) ? 1'b0 : (rx_follow ? ~bus_dom : 1'b1);
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus_drive_dom <= 1'b0;
         lin_rx_out    <= 1'b1;
      end else begin
         bus_drive_dom <= next_drive;
         lin_rx_out    <= next_rx;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_off_reset: assert property (@(posedge clk_sys) $fell(srst) |-> lin_mode_field == lmc_pkg::LMC_OFF)
      else $error("mode not off after reset");
   a_off_nowake: assert property (@(posedge clk_sys) disable iff (srst)
      lin_mode_field == lmc_pkg::LMC_OFF |=> !$rose(wake_status_reg))
      else $error("wake raised in off mode");
   a_norm_gate: assert property (@(posedge clk_sys) disable iff (srst)
      $changed(lin_mode_field) && lin_mode_field == lmc_pkg::LMC_NORMAL |-> $past(ok_norm))
      else $error("normal mode outside chip normal or stop");
   a_rx_held: assert property (@(posedge clk_sys) disable iff (srst)
      wake_ev |=> ##1 !lin_rx_out)
      else $error("receive output not low after wake");
   a_wake_irq: assert property (@(posedge clk_sys) disable iff (srst)
      wake_ev && chip_slp |=> !wake_irq && wake_restart_req)
      else $error("sleep wake raised interrupt");
   a_tx_drop: assert property (@(posedge clk_sys) disable iff (srst)
      tx_exp |=> !bus_drive_dom && lin_fault_flag)
      else $error("driver on after transmit timeout");
   a_uv_off: assert property (@(posedge clk_sys) disable iff (srst)
      !sup_ok |=> !bus_drive_dom)
      else $error("driver on in undervoltage");
   a_no_rearm: assert property (@(posedge clk_sys) disable iff (srst)
      wk == lmc_pkg::LMC_WK_WOKEN && !rearm |=> wk == lmc_pkg::LMC_WK_WOKEN)
      else $error("wake rearmed without cause");
   // Wake accepted, then the FSM holds the woken state
   sequence s_wake_seen;
      wake_ev ##1 wk == lmc_pkg::LMC_WK_WOKEN;
   endsequence
   a_wake_report: assert property (@(posedge clk_sys) disable iff (srst)
      s_wake_seen |-> wake_status_reg ##1 !lin_rx_out)
      else $error("wake not reported");
   a_auto_rearm: assert property (@(posedge clk_sys) disable iff (srst)
      chip_chg && (chip_stop || chip_slp || chip_fs) && wk == lmc_pkg::LMC_WK_WOKEN
      |=> wk == lmc_pkg::LMC_WK_IDLE)
      else $error("wake not rearmed on chip mode entry");
   a_fs_force: assert property (@(posedge clk_sys) disable iff (srst)
      chip_chg && chip_fs |=> lin_mode_field == lmc_pkg::LMC_WAKE)
      else $error("wake mode not entered on fail-safe");
endmodule

`default_nettype wire

//--- hw/lmc_pkg.sv
package lmc_pkg;
   // ----------------------------------------
   // Transceiver mode field codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      LMC_OFF    = 2'h0,
      LMC_WAKE   = 2'h1,
      LMC_NORMAL = 2'h2,
      LMC_RXONLY = 2'h3
   } lmc_mode_t;

   // ----------------------------------------
   // Chip operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      LMC_CHIP_NORMAL  = 3'h0,
      LMC_CHIP_STOP    = 3'h1,
      LMC_CHIP_SLEEP   = 3'h2,
      LMC_CHIP_RESTART = 3'h3,
      LMC_CHIP_FAIL    = 3'h4
   } lmc_chip_t;

   // ----------------------------------------
   // Wake-path FSM states
   // ----------------------------------------
   typedef enum logic [1:0] {
      LMC_WK_IDLE  = 2'h0,
      LMC_WK_ARMED = 2'h1,
      LMC_WK_WOKEN = 2'h2
   } lmc_wk_t;

   // SPI-side configuration staged until chip select rises
   typedef struct packed {
      lmc_mode_t mode;
      logic      low_slope_select;
      logic      flash_select;
   } lmc_cfg_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ             = 40000000;
   localparam int WAKE_FILTER_US     = 30;    // wake_filter_time, least
   localparam int TX_TIMEOUT_US      = 12000; // tx_dominant_timeout, default
   localparam int BUS_TIMEOUT_US     = 12000; // bus_dominant_timeout, default
   localparam int ENABLE_DELAY_US    = 8;     // transceiver enable delay, default
   localparam int WAKE_FILTER_CYC    = (WAKE_FILTER_US * (CLK_HZ / 1000000));
   localparam int TX_TIMEOUT_CYC     = (TX_TIMEOUT_US * (CLK_HZ / 1000000));
   localparam int BUS_TIMEOUT_CYC    = (BUS_TIMEOUT_US * (CLK_HZ / 1000000));
   localparam int ENABLE_DELAY_CYC   = (ENABLE_DELAY_US * (CLK_HZ / 1000000));
   localparam int CNT_W              = 20;
endpackage

//--- dv/lmc_lin_node.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Other LIN node on the single wire
// ----------------------------------------
module lmc_lin_node (
   // Device driver state
   input  wire logic bus_drive_dom,
   // Dominant request of the other node
   input  wire logic node_dom,
   // Bus level seen by the device
   output logic      bus_rx
);
   // Wired-AND bus; the pull-up gives recessive when released
   assign bus_rx = ~(bus_drive_dom | node_dom);
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// Testbench top
// ----------------------------------------
module tb_top;
   logic               clk_sys, srst, spi_cfg_valid, spi_cfg_ready, spi_csn;
   lmc_pkg::lmc_cfg_t  spi_cfg;
   lmc_pkg::lmc_chip_t chip_mode;
   logic               wdog_disabled, wdog_on_bus_wake, fault_clear, node_dom;
   logic               lin_tx_in, bus_rx, bus_supply_ok, bus_drive_dom;
   logic               lin_rx_out, low_slope, slope_bypass, lin_fault_flag;
   lmc_pkg::lmc_mode_t lin_mode_field;
   logic               wake_status_reg, wake_irq, wake_restart_req, wdog_enable_req;
   int                 bad_count = 0, checks = 0, n_irq = 0, n_rst = 0, n_wd = 0, s;

   lmc_mode_ctrl #(.TX_TIMEOUT_CYC(50), .BUS_TIMEOUT_CYC(50), .WAKE_FILTER_CYC(20),
      .ENABLE_DELAY_CYC(5)) u_dut (.clk_sys, .srst, .spi_cfg, .spi_cfg_valid,
      .spi_cfg_ready, .spi_csn, .chip_mode, .wdog_disabled, .wdog_on_bus_wake,
      .fault_clear, .lin_tx_in, .bus_rx, .bus_supply_ok, .bus_drive_dom, .lin_rx_out,
      .low_slope, .slope_bypass, .lin_mode_field, .lin_fault_flag, .wake_status_reg,
      .wake_irq, .wake_restart_req, .wdog_enable_req);

   lmc_lin_node u_node (.bus_drive_dom, .node_dom, .bus_rx);

   // Clock
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Count one-cycle pulses
   always @(posedge clk_sys) begin
      if (wake_irq === 1'h1) n_irq++;
      if (wake_restart_req === 1'h1) n_rst++;
      if (wdog_enable_req === 1'h1) n_wd++;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Hand one config word to the buffer, held until taken
   task automatic push(input lmc_pkg::lmc_mode_t m, input logic ls = 1'h0, input logic fl = 1'h0);
      int k;
      k = 0;
      spi_cfg       <= '{m, ls, fl};
      spi_cfg_valid <= 1'h1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (spi_cfg_ready !== 1'h1 && k < 50);
      if (spi_cfg_ready !== 1'h1)
         bad_count++;
      spi_cfg_valid <= 1'h0;
      cyc(1);
   endtask

   // Chip select pulse applies one buffered word
   task automatic csn_rise();
      spi_csn <= 1'h0;
      cyc(2);
      spi_csn <= 1'h1;
      cyc(8);
   endtask

   task automatic set(input lmc_pkg::lmc_mode_t m, input logic ls = 1'h0, input logic fl = 1'h0);
      push(m, ls, fl);
      csn_rise();
   endtask

   task automatic clr();
      fault_clear <= 1'h1;
      cyc(1);
      fault_clear <= 1'h0;
      cyc(2);
   endtask

   task automatic wake(input int n);
      node_dom <= 1'h1;
      cyc(n);
      node_dom <= 1'h0;
      cyc(6);
   endtask

   task automatic close_out();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      cyc(6000);
      bad_count++;
      close_out();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      srst = 1'h1; spi_cfg = '0; spi_cfg_valid = 1'h0; spi_csn = 1'h1; node_dom = 1'h0;
      chip_mode = lmc_pkg::LMC_CHIP_NORMAL; wdog_disabled = 1'h1; wdog_on_bus_wake = 1'h1;
      fault_clear = 1'h0; lin_tx_in = 1'h1; bus_supply_ok = 1'h1;
      cyc(20);
      srst <= 1'h0;
      cyc(3);
      chk(lin_mode_field, 4'h0);
      chk({low_slope, slope_bypass}, 4'h0);
      $display("reset test done");
      // Host waits out the enable delay before sending
      // tx held recessive
      set(lmc_pkg::LMC_NORMAL);
      cyc(5);
      chk(lin_mode_field, 4'h2);
      lin_tx_in <= 1'h0;
      cyc(7);
      chk({bus_drive_dom, lin_rx_out}, 4'h2);
      lin_tx_in <= 1'h1;
      cyc(4);
      chk(bus_drive_dom, 4'h0);
      // Transmit held low across the enable delay
      lin_tx_in <= 1'h0;
      set(lmc_pkg::LMC_OFF);
      set(lmc_pkg::LMC_NORMAL);
      cyc(10);
      chk(bus_drive_dom, 4'h0);
      lin_tx_in <= 1'h1;
      cyc(3);
      lin_tx_in <= 1'h0;
      cyc(4);
      chk(bus_drive_dom, 4'h1);
      cyc(60);
      chk({bus_drive_dom, lin_fault_flag, lin_mode_field}, 4'h6);
      lin_tx_in <= 1'h1;
      cyc(4);
      lin_tx_in <= 1'h0;
      cyc(4);
      chk(bus_drive_dom, 4'h1);
      lin_tx_in <= 1'h1;
      clr();
      chk(lin_fault_flag, 4'h0);
      $display("transmit test done");
      // Receive-only and under-voltage
      set(lmc_pkg::LMC_RXONLY);
      lin_tx_in <= 1'h0;
      node_dom  <= 1'h1;
      cyc(5);
      chk({bus_drive_dom, lin_rx_out, lin_mode_field}, 4'h3);
      bus_supply_ok <= 1'h0;
      cyc(5);
      chk({bus_drive_dom, lin_rx_out, lin_mode_field}, 4'h7);
      bus_supply_ok <= 1'h1;
      node_dom      <= 1'h0;
      lin_tx_in     <= 1'h1;
      cyc(5);
      $display("receive test done");
      // Bus clamp in off mode, wake ignored
      set(lmc_pkg::LMC_OFF);
      wake(60);
      chk({lin_fault_flag, wake_status_reg, lin_mode_field}, 4'h8);
      clr();
      // Refusals and wake in chip sleep
      chip_mode <= lmc_pkg::LMC_CHIP_SLEEP;
      cyc(3);
      set(lmc_pkg::LMC_NORMAL);
      chk(lin_mode_field, 4'h0);
      set(lmc_pkg::LMC_RXONLY);
      chk(lin_mode_field, 4'h0);
      set(lmc_pkg::LMC_WAKE);
      chk(lin_mode_field, 4'h1);
      wake(10);
      chk(wake_status_reg, 4'h0);
      s = n_irq;
      wake(40);
      chk({wake_status_reg, lin_rx_out}, 4'h2);
      chk(n_rst[3:0], 4'h1);
      chk(4'(n_irq - s), 4'h0);
      $display("sleep wake test done");
      // Wake in chip stop
      clr();
      chip_mode <= lmc_pkg::LMC_CHIP_STOP;
      cyc(3);
      wake(40);
      chk({wake_status_reg, lin_rx_out}, 4'h2);
      chk(4'(n_irq - s), 4'h1);
      chk(n_rst[3:0], 4'h1);
      chk(n_wd[3:0], 4'h1);
      chk(lin_mode_field, 4'h1);
      clr();
      wake(40);
      chk(wake_status_reg, 4'h0);
      set(lmc_pkg::LMC_NORMAL);
      chk(lin_rx_out, 4'h1);
      set(lmc_pkg::LMC_WAKE);
      wake(40);
      chk(wake_status_reg, 4'h1);
      set(lmc_pkg::LMC_OFF);
      chip_mode <= lmc_pkg::LMC_CHIP_FAIL;
      cyc(3);
      chk(lin_mode_field, 4'h1);
      wake(40);
      chk(n_rst[3:0], 4'h2);
      set(lmc_pkg::LMC_OFF);
      chk(lin_mode_field, 4'h0);
      $display("stop wake test done");
      // Slope selection
      chip_mode <= lmc_pkg::LMC_CHIP_NORMAL;
      set(lmc_pkg::LMC_NORMAL, 1'h0, 1'h1);
      chk({low_slope, slope_bypass}, 4'h1);
      set(lmc_pkg::LMC_NORMAL, 1'h1, 1'h0);
      chk({low_slope, slope_bypass, lin_mode_field}, 4'ha);
      chip_mode <= lmc_pkg::LMC_CHIP_STOP;
      set(lmc_pkg::LMC_NORMAL, 1'h0, 1'h1);
      chk({low_slope, slope_bypass}, 4'h2);
      $display("slope test done");
      // Two words buffered, one applied per chip select
      push(lmc_pkg::LMC_RXONLY);
      push(lmc_pkg::LMC_OFF);
      cyc(1);
      chk({spi_cfg_ready, lin_mode_field}, 4'h2);
      csn_rise();
      chk(lin_mode_field, 4'h3);
      csn_rise();
      chk(lin_mode_field, 4'h0);
      $display("buffer test done");
      close_out();
   end
endmodule

`default_nettype wire
